// ### src/psbc_pkg.sv
// shared constants and carriers for the pipelined burst sram control block
package psbc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 15;
  localparam int DATA_W      = 32;
  localparam int LANES       = 4;
  localparam int LANE_W      = 8;
  localparam int BURST_W     = 2;
  localparam int WORDS       = 32768;

  // ----------------------------------------------------------------
  // timing and buffer figures
  // ----------------------------------------------------------------
  localparam int WAKE_CYCLES = 2;
  localparam int WBUF_DEPTH  = 2;

  localparam logic [LANES-1:0]   MASK_ALL  = 4'hF;
  localparam logic [LANES-1:0]   MASK_NONE = 4'h0;
  localparam logic [BURST_W-1:0] CNT_START = 2'h0;
  localparam logic [BURST_W-1:0] CNT_ONE   = 2'h1;

  // power state, gray along awake -> sleep -> waking
  typedef enum logic [1:0] {
    PSBC_AWAKE  = 2'h0,
    PSBC_ASLEEP = 2'h1,
    PSBC_WAKING = 2'h3
  } psbc_power_e;

  // one captured write beat
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  mask;
  } psbc_write_s;

endpackage

// ### src/psbc_sram.sv
// pipelined burst sram: control, burst counter, write buffer, read pipeline and array
// ----------------------------------------------------------------
// Summary of operation
// - inputs sampled on rising clk; output enable and sleep request are asynchronous
// - array holds 32K words of 32 bits addressed by fifteen address inputs
// - sleep request high holds the block in power-down with all state kept
// - after sleep request falls, two wake cycles pass before accesses resume
// - processor strobe low with selects active loads address and starts a read
// - read data passes data-out register then output buffer on successive edges
// - burst step ignored on the edge taking the processor strobe
// - read burst advances when lane writes high and burst step low
// - primary select high blocks the processor strobe
// - global write writes all bytes; else gate and lane write pick bytes
// - any lane write sampled low turns data drivers off
// - lane writes disregarded on the processor strobe edge
// - lane write low captures bus data; advances burst if step low too
// - each lane write governs its own byte lane in order
// - controller strobe start samples lane writes on the same edge
// - burst address from 2-bit counter on two low address bits
// - burst counter wraps to its start after four beats
// - order select low gives binary count modulo four from start
// - order select high gives start exclusive-ored with count
// - burst step high holds the burst address as a wait state
// - output drive starts two cycles after select, stops after deselect
// - new burst needs all three selects active; otherwise strobe deselects
// - read after write returns the just-written bytes
// ----------------------------------------------------------------
`timescale 1ns/1ps

module psbc_sram #(
  parameter int ADDR_W = psbc_pkg::ADDR_W,
  parameter int DATA_W = psbc_pkg::DATA_W
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [psbc_pkg::ADDR_W-1:0]  word_address,
  input  wire logic                         proc_addr_strobe_n,
  input  wire logic                         ctrl_addr_strobe_n,
  input  wire logic                         burst_step_n,
  input  wire logic                         global_write_n,
  input  wire logic                         byte_write_gate_n,
  input  wire logic [psbc_pkg::LANES-1:0]   lane_write_n,
  input  wire logic                         primary_select_n,
  input  wire logic                         secondary_select,
  input  wire logic                         tertiary_select_n,
  input  wire logic                         output_enable_n,
  input  wire logic                         sleep_request,
  input  wire logic                         burst_order_select,
  input  wire logic [psbc_pkg::DATA_W-1:0]  lane_data_in,
  output logic      [psbc_pkg::DATA_W-1:0]  lane_data_out,
  output logic      [psbc_pkg::DATA_W-1:0]  lane_data_oe_n,
  output logic                              write_ready
);
  import psbc_pkg::*;

  // ----------------------------------------------------------------
  // burst low-bit sequence
  // ----------------------------------------------------------------
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic               interleave);
    burst_low = interleave ? (start ^ cnt) : BURST_W'(start + cnt);
  endfunction

  // byte merge of a write beat over older data
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input psbc_write_s     wr,
                                              input logic [ADDR_W-1:0] addr,
                                              input logic            valid);
    merge = old;
    for (int i = 0; i < LANES; i++) begin
      if (valid && wr.addr == addr && wr.mask[i]) begin
        merge[i*LANE_W +: LANE_W] = wr.data[i*LANE_W +: LANE_W];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // asynchronous inputs: two flops each
  // ----------------------------------------------------------------
  logic sleep_meta, sleep_sync, oe_meta, oe_sync_n;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      oe_meta    <= 1'b1;
      oe_sync_n  <= 1'b1;
    end else begin
      sleep_meta <= sleep_request;
      sleep_sync <= sleep_meta;
      oe_meta    <= output_enable_n;
      oe_sync_n  <= oe_meta;
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  psbc_power_e power_state, next_power_state;
  logic [1:0]  wake_cnt, next_wake_cnt;
  logic        awake;

  assign awake = (power_state == PSBC_AWAKE);

  // wake counter stays short so the controller sees a fixed delay
  always_comb begin
    next_power_state = power_state;
    next_wake_cnt    = wake_cnt;
    case (power_state)
      PSBC_AWAKE: begin
        if (sleep_sync) next_power_state = PSBC_ASLEEP;
      end
      PSBC_ASLEEP: begin
        next_wake_cnt = 2'h0;
        if (!sleep_sync) next_power_state = PSBC_WAKING;
      end
      PSBC_WAKING: begin
        if (sleep_sync) begin
          next_power_state = PSBC_ASLEEP;
        end else if (wake_cnt == 2'(WAKE_CYCLES - 1)) begin
          next_power_state = PSBC_AWAKE;
        end else begin
          next_wake_cnt = 2'(wake_cnt + 2'h1);
        end
      end
      default: next_power_state = PSBC_ASLEEP;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_state <= PSBC_AWAKE;
      wake_cnt    <= 2'h0;
    end else begin
      power_state <= next_power_state;
      wake_cnt    <= next_wake_cnt;
    end
  end

  // ----------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]  burst_base;
  logic [BURST_W-1:0] burst_cnt;
  logic               burst_active;
  wire                sel_ok     = ~primary_select_n & secondary_select & ~tertiary_select_n;
  wire                proc_addr_strobe_n_seen  = ~proc_addr_strobe_n & ~primary_select_n;
  wire                ctrl_addr_strobe_n_seen  = ~ctrl_addr_strobe_n & ~proc_addr_strobe_n_seen;
  wire                proc_addr_strobe_n_go    = awake & proc_addr_strobe_n_seen & sel_ok;
  wire                ctrl_addr_strobe_n_go    = awake & ctrl_addr_strobe_n_seen & sel_ok;
  wire                deselect   = awake & (proc_addr_strobe_n_seen | ctrl_addr_strobe_n_seen) & ~sel_ok;
  wire                cont       = awake & burst_active & ~proc_addr_strobe_n_seen & ~ctrl_addr_strobe_n_seen;
  wire [LANES-1:0]    lanes_low  = proc_addr_strobe_n_seen ? MASK_NONE : ~lane_write_n;
  wire [LANES-1:0]    wr_mask    = ~global_write_n ? MASK_ALL :
                                   (~byte_write_gate_n ? lanes_low : MASK_NONE);
  wire                is_write   = ~proc_addr_strobe_n_seen & (|wr_mask);
  wire                step       = cont & ~burst_step_n;
  // a stepping edge already accesses the next beat, not the one it leaves
  wire [BURST_W-1:0]  beat_cnt   = step ? BURST_W'(burst_cnt + CNT_ONE) : burst_cnt;
  wire [ADDR_W-1:0]   cur_addr   = {burst_base[ADDR_W-1:BURST_W],
                                    burst_low(burst_base[BURST_W-1:0], beat_cnt, burst_order_select)};
  wire [ADDR_W-1:0]   acc_addr   = (proc_addr_strobe_n_go | ctrl_addr_strobe_n_go) ? word_address : cur_addr;
  wire                rd_take    = proc_addr_strobe_n_go | ((ctrl_addr_strobe_n_go | cont) & ~is_write);
  wire                wr_take    = (ctrl_addr_strobe_n_go | cont) & is_write;

  // ----------------------------------------------------------------
  // address register and burst counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      burst_base   <= '0;
      burst_cnt    <= CNT_START;
      burst_active <= 1'b0;
    end else if (proc_addr_strobe_n_go || ctrl_addr_strobe_n_go) begin
      burst_base   <= word_address;
      burst_cnt    <= CNT_START;
      burst_active <= 1'b1;
    end else if (deselect) begin
      burst_active <= 1'b0;
    end else if (step) begin
      burst_cnt    <= beat_cnt;
    end
  end

  // ----------------------------------------------------------------
  // two-entry write buffer; reads own the array port first
  // ----------------------------------------------------------------
  psbc_write_s wbuf [WBUF_DEPTH];
  logic        wbuf_head, wbuf_tail;
  logic [1:0]  wbuf_count;
  logic        rd_req;
  psbc_write_s push_beat;
  wire         push_valid = wr_take;
  wire         push_ready = (wbuf_count != 2'(WBUF_DEPTH));
  wire         push_fire  = push_valid & push_ready;
  wire         pop_valid  = (wbuf_count != 2'h0);
  wire         pop_ready  = ~rd_req;           // array busy with a read stalls the drain
  wire         pop_fire   = pop_valid & pop_ready;
  wire [1:0]   next_wbuf_count = 2'(wbuf_count + {1'b0, push_fire} - {1'b0, pop_fire});

  assign push_beat = '{addr: acc_addr, data: lane_data_in, mask: wr_mask};

  // full buffer is advertised so no captured word is ever overwritten
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wbuf_head   <= 1'b0;
      wbuf_tail   <= 1'b0;
      wbuf_count  <= 2'h0;
      write_ready <= 1'b1;
    end else begin
      if (push_fire) begin
        wbuf[wbuf_tail] <= push_beat;
        wbuf_tail       <= ~wbuf_tail;
      end
      if (pop_fire) wbuf_head <= ~wbuf_head;
      wbuf_count  <= next_wbuf_count;
      write_ready <= (next_wbuf_count != 2'(WBUF_DEPTH));
    end
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [WORDS];
  psbc_write_s       drain_beat;

  assign drain_beat = wbuf[wbuf_head];

  // no reset on the array, it is plain storage
  always_ff @(posedge clk) begin
    if (pop_fire) begin
      for (int i = 0; i < LANES; i++) begin
        if (drain_beat.mask[i]) mem[drain_beat.addr][i*LANE_W +: LANE_W] <= drain_beat.data[i*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // read pipeline: address, data-out register, output buffer
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] data_out_reg;
  logic              drv1;
  wire               older_valid = (wbuf_count == 2'h2);
  wire               newer_valid = (wbuf_count != 2'h0);
  wire [DATA_W-1:0]  rd_old      = merge(mem[rd_addr], wbuf[wbuf_head], rd_addr, older_valid);
  wire [DATA_W-1:0]  rd_fwd      = merge(rd_old, wbuf[~wbuf_tail], rd_addr, newer_valid);
  wire               drive_next  = awake & drv1 & ~oe_sync_n & ~(|lanes_low) & ~deselect;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_req  <= 1'b0;
      rd_addr <= '0;
    end else if (awake) begin
      rd_req  <= rd_take;
      rd_addr <= acc_addr;
    end
  end

  // everything but the drive enables holds while not awake, so no state is lost in sleep
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_out_reg   <= '0;
      drv1           <= 1'b0;
      lane_data_out  <= '0;
      lane_data_oe_n <= '1;
    end else begin
      if (awake) begin
        drv1 <= rd_req & ~deselect;          // a beat in flight must not re-open the drivers
        if (rd_req) data_out_reg <= rd_fwd;
        lane_data_out <= data_out_reg;
      end
      lane_data_oe_n <= {DATA_W{~drive_next}};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sleep_hiz_a: assert property (@(posedge clk) disable iff (reset)
    (power_state != PSBC_AWAKE) |=> (&lane_data_oe_n))
    else $error("drivers on while not awake");

  wake_delay_a: assert property (@(posedge clk) disable iff (reset)
    (power_state == PSBC_ASLEEP && !sleep_sync) ##1 (!sleep_sync)[*2] |=> (power_state == PSBC_AWAKE))
    else $error("wake-up did not complete in two cycles");

  wake_early_a: assert property (@(posedge clk) disable iff (reset)
    (power_state == PSBC_ASLEEP) |=> !awake ##1 !awake)
    else $error("woke before two cycles");

  strobe_load_a: assert property (@(posedge clk) disable iff (reset)
    proc_addr_strobe_n_go |=> (burst_base == $past(word_address)) && (burst_cnt == CNT_START) && rd_req)
    else $error("processor strobe did not load a read");

  step_ignored_a: assert property (@(posedge clk) disable iff (reset)
    (proc_addr_strobe_n_go && !burst_step_n) |=> (burst_cnt == CNT_START))
    else $error("burst stepped on processor strobe edge");

  burst_step_a: assert property (@(posedge clk) disable iff (reset)
    (cont && !burst_step_n) |=> (burst_cnt == $past(burst_cnt) + CNT_ONE))
    else $error("burst did not advance");

  wait_hold_a: assert property (@(posedge clk) disable iff (reset)
    (cont && burst_step_n) |=> $stable(burst_cnt) && $stable(burst_base))
    else $error("burst moved during wait state");

  strobe_block_a: assert property (@(posedge clk) disable iff (reset)
    (awake && primary_select_n && ctrl_addr_strobe_n && !proc_addr_strobe_n) |=> $stable(burst_base))
    else $error("blocked processor strobe loaded an address");

  lane_off_a: assert property (@(posedge clk) disable iff (reset)
    (|(~lane_write_n) && !proc_addr_strobe_n_seen) |=> (&lane_data_oe_n))
    else $error("drivers on while lane write low");

  pipe_stage_a: assert property (@(posedge clk) disable iff (reset)
    (awake && rd_req) ##1 awake |=> (lane_data_out == $past(rd_fwd, 2)))
    else $error("read data not two stages later");

  global_all_a: assert property (@(posedge clk) disable iff (reset)
    (wr_take && !global_write_n) |-> (wr_mask == MASK_ALL))
    else $error("global write missed a byte");

  deselect_off_a: assert property (@(posedge clk) disable iff (reset)
    deselect |=> (&lane_data_oe_n) ##1 (&lane_data_oe_n))
    else $error("drivers on after deselect");

  linear_step_a: assert property (@(posedge clk) disable iff (reset)
    (step && !burst_order_select) |=> (rd_addr[BURST_W-1:0] == BURST_W'(burst_base[BURST_W-1:0] + burst_cnt)))
    else $error("linear burst accessed wrong beat");

  interleave_step_a: assert property (@(posedge clk) disable iff (reset)
    (step && burst_order_select) |=> (rd_addr[BURST_W-1:0] == (burst_base[BURST_W-1:0] ^ burst_cnt)))
    else $error("interleaved burst accessed wrong beat");

  write_capture_a: assert property (@(posedge clk) disable iff (reset)
    (wr_take && push_ready) |=> (wbuf[~wbuf_tail] == $past(push_beat)))
    else $error("write beat not captured");

endmodule

// ### testbench/pipelined_burst_sram_control_test.sv
// self-checking bench for the pipelined burst sram control block
`timescale 1ns/1ps

module pipelined_burst_sram_control_test;
  import psbc_pkg::*;

  logic              clk, reset, ps_n, cs_n, step_n, gw_n, bwg_n;
  logic              sel1_n, sel2, sel3_n, oe_n, sleep, order, host_drive, wr_rdy, clash;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  lanes_n;
  logic [DATA_W-1:0] host_data, bus, dout, doe_n;
  logic [DATA_W-1:0] exp_mem [int];
  int                failures, compares, cycles;

  psbc_sram i_dut (.clk(clk), .reset(reset), .word_address(addr), .proc_addr_strobe_n(ps_n),
    .ctrl_addr_strobe_n(cs_n), .burst_step_n(step_n), .global_write_n(gw_n), .byte_write_gate_n(bwg_n),
    .lane_write_n(lanes_n), .primary_select_n(sel1_n), .secondary_select(sel2), .tertiary_select_n(sel3_n),
    .output_enable_n(oe_n), .sleep_request(sleep), .burst_order_select(order), .lane_data_in(bus),
    .lane_data_out(dout), .lane_data_oe_n(doe_n), .write_ready(wr_rdy));

  psbc_bus_model i_bus (.clk(clk), .host_drive(host_drive), .host_data(host_data), .mem_data(dout),
    .mem_oe_n(doe_n), .bus(bus), .clash(clash));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // watchdog: the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("ERROR watchdog expected finish seen hang");
      summarize();
    end
  end

  task automatic check_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // inputs always change the same small delay after the edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int n);
    ps_n = 1'b1;
    cs_n = 1'b1;
    step_n = 1'b1;
    gw_n = 1'b1;
    bwg_n = 1'b1;
    lanes_n = MASK_ALL;
    host_drive = 1'b0;
    oe_n = 1'b0;
    repeat (n) tick();
  endtask

  // single write started by the controller strobe; outputs parked first to avoid contention
  task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic g,
                            input logic b, input logic [LANES-1:0] l);
    int guard;
    guard = 0;
    oe_n = 1'b1;
    repeat (3) tick();
    while (wr_rdy !== 1'b1 && guard < 20) begin
      tick();
      guard++;
    end
    addr = a;
    cs_n = 1'b0;
    ps_n = 1'b1;
    gw_n = g;
    bwg_n = b;
    lanes_n = l;
    host_drive = 1'b1;
    host_data = d;
    tick();
    for (int i = 0; i < LANES; i++)
      if (!g || (!b && !l[i])) exp_mem[int'(a)][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    cs_n = 1'b1;
    gw_n = 1'b1;
    bwg_n = 1'b1;
    lanes_n = MASK_ALL;
    host_drive = 1'b0;
    tick(); // one edge passes so the next call never re-raises a strobe in this step
  endtask

  // five-beat read; steps[i] is the step input at beat i, word of beat i shows two edges later
  task automatic read_burst(input logic [ADDR_W-1:0] a, input logic [4:0] steps);
    logic [1:0]        cnt;
    logic [ADDR_W-1:0] q [5];
    cnt = 2'h0;
    oe_n = 1'b0;
    for (int i = 0; i < 7; i++) begin
      ps_n = (i != 0);
      cs_n = (i != 0);
      gw_n = (i != 0);
      lanes_n = (i == 0) ? MASK_NONE : MASK_ALL;
      addr = (i == 0) ? a : ~a;
      step_n = (i < 5) ? steps[i] : 1'b1;
      if (i > 0 && i < 5 && !steps[i])
        cnt = cnt + 2'h1;
      if (i < 5)
        q[i] = {a[ADDR_W-1:2], order ? (a[1:0] ^ cnt) : (a[1:0] + cnt)};
      tick();
      if (i >= 2) begin
        check_word("read data", exp_mem[int'(q[i-2])], dout);
        check_word("drive enable", '0, doe_n);
      end
    end
    idle(1);
  endtask

  initial begin
    failures = 0;
    compares = 0;
    cycles = 0;
    reset = 1'b1;
    order = 1'b0;
    sel1_n = 1'b0;
    sel2 = 1'b1;
    sel3_n = 1'b0;
    sleep = 1'b0;
    addr = '0;
    host_data = '0;
    idle(0);
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    // whole-word writes, then lanes 0 and 3 singly, a gated-off write and lanes 1 and 2 together
    for (int k = 0; k < 4; k++)
      write_word(15'h0120 + 15'(k), 32'hC0DE0000 + 32'(k), 1'b0, 1'b1, MASK_ALL);
    write_word(15'h0121, 32'h11223344, 1'b1, 1'b0, 4'hE);
    write_word(15'h0122, 32'h55667788, 1'b1, 1'b0, 4'h7);
    write_word(15'h0123, 32'h99AABBCC, 1'b1, 1'b1, MASK_NONE);
    write_word(15'h0120, 32'hDDEEFF00, 1'b1, 1'b0, 4'h9);
    read_burst(15'h0121, 5'b00000);
    $display("linear burst with wrap done");
    // read straight after a write, with wait states
    write_word(15'h0122, 32'h5A5A5A5A, 1'b0, 1'b1, MASK_ALL);
    read_burst(15'h0122, 5'b10100);
    $display("forwarding and wait states done");
    // order is only changed while held in reset
    reset = 1'b1;
    order = 1'b1;
    tick();
    reset = 1'b0;
    idle(2);
    read_burst(15'h0122, 5'b00000);
    $display("interleaved burst done");
    // strobe with primary select high must not restart; then deselect
    ps_n = 1'b0;
    sel1_n = 1'b1;
    addr = 15'h0120;
    tick();
    idle(2);
    check_word("blocked strobe data", exp_mem[32'h0122], dout);
    check_word("blocked strobe enable", '0, doe_n);
    cs_n = 1'b0;
    sel1_n = 1'b0;
    sel2 = 1'b0;
    tick();
    sel2 = 1'b1;
    idle(1);
    check_word("deselect enable", '1, doe_n);
    $display("select handling done");
    // power-down: no drive, no write taken, contents kept
    sleep = 1'b1;
    idle(4);
    check_word("sleep enable", '1, doe_n);
    addr = 15'h0121;
    cs_n = 1'b0;
    gw_n = 1'b0;
    host_drive = 1'b1;
    host_data = 32'hBADC0FFE;
    tick();
    idle(1);
    check_word("sleep enable", '1, doe_n);
    sleep = 1'b0;
    idle(8);
    read_burst(15'h0121, 5'b11110);
    $display("power-down done");
    check_word("bus contention", '0, {31'h0, clash});
    summarize();
  end
endmodule

// ### testbench/psbc_bus_model.sv
// controller side of the shared data bus: resolves both drivers and flags contention
`timescale 1ns/1ps

module psbc_bus_model (
  input  wire logic                        clk,
  input  wire logic                        host_drive,
  input  wire logic [psbc_pkg::DATA_W-1:0] host_data,
  input  wire logic [psbc_pkg::DATA_W-1:0] mem_data,
  input  wire logic [psbc_pkg::DATA_W-1:0] mem_oe_n,
  output logic      [psbc_pkg::DATA_W-1:0] bus,
  output logic                             clash
);
  import psbc_pkg::*;

  logic [DATA_W-1:0] last_bus = '0;

  // a released line toggles each cycle, so a stale hold never passes for data
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      if (!mem_oe_n[i])
        bus[i] = mem_data[i];
      else if (host_drive)
        bus[i] = host_data[i];
      else
        bus[i] = ~last_bus[i];
    end
  end

  logic seen_clash = 1'b0;

  assign clash = seen_clash;

  // sticky: any edge where both sides drive is remembered to the end
  always @(posedge clk) begin
    last_bus <= bus;
    if (host_drive && mem_oe_n !== '1)
      seen_clash <= 1'b1;
  end
endmodule
